// *** logic/imu_mode_power_sequencer.sv ***
// Mode and power-state sequencer with serial stabilisation stream.
`timescale 1ns/1ps
// Overview of operation
// - Gyro code 110 streams; accelerometer unavailable.
// - Wire-select bit picks 3-wire or 4-wire.
// - Gyro 111, accel 000 gives low-latency mode.
// - Reset or power-up ends in default state.
// - Six-axis fusion outputs increments, not samples.
// - Nine-axis fusion adds magnetic field values.
// - On-demand fusion results go out on poll.
// - Wake interval counts from second line rising.
// - Three rate periods settle after wake.
// - Sensors off within one to two periods.
// - Full boot takes 1.75 seconds.
// - Gyro wake 60 ms then settling.
// - Accel wake 3 ms then settling.
// - Mag wake 12 ms then settling.
// - Warm-start gyro wake 5 ms then settling.
// - Sensors-off transitions limited by host transfer; leaving power-down here reboots fully.
// - Shutdown bit powers down, keeps interface, contents.
// - Default state keeps sensors off, clock running.
module imu_mode_power_sequencer #(
  parameter int unsigned BOOT_CYC = imu_seq_pkg::BOOT_CYC, // Boot length.
  parameter int unsigned GYRO_CYC = imu_seq_pkg::GYRO_CYC, // Gyro wake.
  parameter int unsigned ACC_CYC  = imu_seq_pkg::ACC_CYC,  // Accel wake.
  parameter int unsigned MAG_CYC  = imu_seq_pkg::MAG_CYC,  // Mag wake.
  parameter int unsigned WARM_CYC = imu_seq_pkg::WARM_CYC  // Warm wake.
) (
  input  wire logic                           i_ref_clk,      // Core clock.
  input  wire logic                           i_rst_n,        // Async reset.
  input  wire imu_seq_pkg::ctrl_t             i_ctrl,         // Control bits.
  input  wire logic [imu_seq_pkg::ODR_W-1:0]  i_odr_cycles,   // Rate period.
  input  wire imu_seq_pkg::sample_t           i_sample,       // Sensor word.
  input  wire logic                           i_sample_valid, // Word valid.
  output logic                                o_sample_ready, // Buffer room.
  input  wire logic                           i_link_clk,     // Host clock pin.
  input  wire logic                           i_poll,         // Host poll pin.
  output logic                                o_sdo,          // Serial data.
  output logic                                o_sdo_oe,       // Data drive.
  output logic                                o_irq_line_one, // First line.
  output logic                                o_irq_line_two, // Second line.
  output imu_seq_pkg::mode_t                  o_mode,         // Active mode.
  output imu_seq_pkg::out_kind_t              o_out_kind,     // Output form.
  output logic                                o_accel_avail,  // Accel usable.
  output logic                                o_data_ready,   // Data valid.
  output logic                                o_boot_busy     // Booting.
);
  // ********************************************************
  // Decoding
  // ********************************************************
  // Mode chosen by the control bits; stabilisation codes take priority.
  function automatic imu_seq_pkg::mode_t decode_mode(imu_seq_pkg::ctrl_t c);
    if (c.gyro_rate_code == imu_seq_pkg::GRATE_OIS) begin
      decode_mode = imu_seq_pkg::MD_OIS;
    end else if (c.gyro_rate_code == imu_seq_pkg::GRATE_LL &&
                 c.accel_rate_code == imu_seq_pkg::ARATE_LL) begin
      decode_mode = imu_seq_pkg::MD_OPTICAL_STAB_LOW_LATENCY;
    end else if (c.accel_on && c.gyro_on && c.fusion_on && c.mag_on) begin
      decode_mode = imu_seq_pkg::MD_FUSE9;
    end else if (c.accel_on && c.gyro_on && c.fusion_on &&
                 !c.accel_rate_code[2]) begin
      decode_mode = imu_seq_pkg::MD_FUSE6;
    end else if (c.accel_on || c.gyro_on || c.mag_on) begin
      decode_mode = imu_seq_pkg::MD_RAW;
    end else begin
      decode_mode = imu_seq_pkg::MD_OFF;
    end
  endfunction : decode_mode

  imu_seq_pkg::state_t st_q;          // Sequencer state.
  imu_seq_pkg::mode_t  want_mode;     // Mode asked for now.
  logic                want;          // Some sensor is asked for.
  logic [31:0]         cnt_q;         // Boot and wake down-counter.
  logic [31:0]         wake_cyc;      // Wake length for the request.
  logic                warm_q;        // Gyro held in warm start.
  logic [imu_seq_pkg::ODR_W-1:0] odr_q; // Rate period counter.
  logic                tick;          // Last cycle of a rate period.
  logic [1:0]          per_q;         // Settle or stop period count.

  assign want_mode = decode_mode(i_ctrl);
  assign want      = (want_mode != imu_seq_pkg::MD_OFF);
  assign tick      = (odr_q == '0);

  // Gyro wake overrides mag, mag overrides accel; warm start shortens the gyro.
  always_comb begin
    wake_cyc = 32'h1;
    if (i_ctrl.accel_on) begin
      wake_cyc = ACC_CYC;
    end
    if (i_ctrl.mag_on) begin
      wake_cyc = MAG_CYC;
    end
    if (i_ctrl.gyro_on || want_mode == imu_seq_pkg::MD_OIS ||
        want_mode == imu_seq_pkg::MD_OPTICAL_STAB_LOW_LATENCY) begin
      wake_cyc = warm_q ? WARM_CYC : GYRO_CYC;
    end
  end

  // ********************************************************
  // Rate period timer
  // ********************************************************
  // Free-running, so settling and shutdown line up with sample periods.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      odr_q <= '0;
    end else if (tick) begin
      odr_q <= i_odr_cycles - 1'b1;
    end else begin
      odr_q <= odr_q - 1'b1;
    end
  end

  // ********************************************************
  // Power state machine
  // ********************************************************
  // Default to power-down takes one cycle; only the host's own transfer time
  // limits it. Leaving power-down reboots in full, taking BOOT_CYC cycles.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q  <= imu_seq_pkg::ST_BOOT;
      cnt_q <= BOOT_CYC - 1;
      per_q <= 2'h0;
    end else begin
      case (st_q)
        imu_seq_pkg::ST_BOOT: begin
          // Full boot; the host should reset only for a full reboot.
          if (cnt_q == 32'h0) begin
            st_q <= imu_seq_pkg::ST_DEFAULT;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        imu_seq_pkg::ST_DEFAULT: begin
          // Sensors stay off here; the clock keeps running.
          if (i_ctrl.sensor_shutdown) begin
            st_q <= imu_seq_pkg::ST_PDOWN;
          end else if (want) begin
            st_q  <= imu_seq_pkg::ST_WAKE;
            cnt_q <= wake_cyc - 32'h1;
          end
        end
        imu_seq_pkg::ST_WAKE: begin
          if (i_ctrl.sensor_shutdown || !want) begin
            st_q  <= imu_seq_pkg::ST_STOP;
            per_q <= 2'h0;
          end else if (cnt_q == 32'h0) begin
            st_q  <= imu_seq_pkg::ST_SETTLE;
            per_q <= 2'h0;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        imu_seq_pkg::ST_SETTLE: begin
          if (i_ctrl.sensor_shutdown || !want) begin
            st_q  <= imu_seq_pkg::ST_STOP;
            per_q <= 2'h0;
          end else if (tick) begin
            per_q <= per_q + 2'h1;
            if (per_q == imu_seq_pkg::SETTLE_LAST) begin
              st_q <= imu_seq_pkg::ST_RUN;
            end
          end
        end
        imu_seq_pkg::ST_RUN: begin
          if (i_ctrl.sensor_shutdown || !want) begin
            st_q  <= imu_seq_pkg::ST_STOP;
            per_q <= 2'h0;
          end
        end
        imu_seq_pkg::ST_STOP: begin
          // The first tick comes within one period, the second one later.
          if (tick) begin
            per_q <= per_q + 2'h1;
            if (per_q == imu_seq_pkg::STOP_LAST) begin
              st_q <= i_ctrl.sensor_shutdown ? imu_seq_pkg::ST_PDOWN
                                             : imu_seq_pkg::ST_DEFAULT;
            end
          end
        end
        imu_seq_pkg::ST_PDOWN: begin
          // Leaving power-down reboots fully.
          if (!i_ctrl.sensor_shutdown) begin
            st_q  <= imu_seq_pkg::ST_BOOT;
            cnt_q <= BOOT_CYC - 1;
          end
        end
        default: begin
          st_q <= imu_seq_pkg::ST_BOOT;
        end
      endcase
    end
  end

  // Warm start is held while idle with the gyro warm code set.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_q <= 1'b0;
    end else if (st_q == imu_seq_pkg::ST_DEFAULT) begin
      warm_q <= (i_ctrl.gyro_rate_code == imu_seq_pkg::GRATE_WARM) && !want;
    end else if (st_q != imu_seq_pkg::ST_WAKE) begin
      warm_q <= 1'b0;
    end
  end

  // Mode and output form latch at wake; power-down keeps them.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode     <= imu_seq_pkg::MD_OFF;
      o_out_kind <= imu_seq_pkg::OUT_RAW;
    end else if (st_q == imu_seq_pkg::ST_DEFAULT && want &&
                 !i_ctrl.sensor_shutdown) begin
      o_mode <= want_mode;
      case (want_mode)
        imu_seq_pkg::MD_FUSE6: o_out_kind <= imu_seq_pkg::OUT_FUSE6;
        imu_seq_pkg::MD_FUSE9: o_out_kind <= imu_seq_pkg::OUT_FUSE9;
        default:               o_out_kind <= imu_seq_pkg::OUT_RAW;
      endcase
    end
  end

  assign o_data_ready  = (st_q == imu_seq_pkg::ST_RUN);
  assign o_boot_busy   = (st_q == imu_seq_pkg::ST_BOOT);
  assign o_accel_avail = o_data_ready && (o_mode != imu_seq_pkg::MD_OIS);

  // ********************************************************
  // Two-entry buffer
  // ********************************************************
  imu_seq_pkg::sample_t buf_q [2]; // Buffered words.
  logic       wp_q;                // Write slot.
  logic       rp_q;                // Read slot.
  logic [1:0] cnt2_q;              // Words held.
  logic       push;                // Word taken in.
  logic       pop;                 // Word moved to the shifter.

  assign o_sample_ready = (cnt2_q != 2'h2);
  assign push = i_sample_valid && o_sample_ready;

  // A stalled shifter fills the buffer, and the sensor side then waits.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      cnt2_q <= 2'h0;
    end else begin
      wp_q   <= wp_q ^ push;
      rp_q   <= rp_q ^ pop;
      cnt2_q <= cnt2_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      buf_q[wp_q] <= i_sample;
    end
  end

  // ********************************************************
  // Link pins and serial shifter
  // ********************************************************
  logic [2:0] lk_q;      // Link clock synchroniser.
  logic [2:0] pl_q;      // Poll synchroniser.
  logic       poll_q;    // Poll waiting.
  logic [imu_seq_pkg::WORD_W-1:0] sh_q; // Shift register.
  logic [4:0] bits_q;    // Bits left in the word.
  logic       lk_fall;   // Falling link edge.
  logic       od;        // On-demand fusion active.

  // Only the settled second and third stages are compared.
  assign lk_fall = lk_q[2] && !lk_q[1];
  assign od   = i_ctrl.on_demand_select && (o_mode == imu_seq_pkg::MD_FUSE6 ||
                                            o_mode == imu_seq_pkg::MD_FUSE9);
  assign pop  = o_data_ready && (bits_q == 5'h0) && (cnt2_q != 2'h0) &&
                (!od || poll_q);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_q <= 3'h0;
      pl_q <= 3'h0;
    end else begin
      lk_q <= {lk_q[1:0], i_link_clk};
      pl_q <= {pl_q[1:0], i_poll};
    end
  end

  // A poll edge that meets a load stays pending: set wins.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      poll_q <= 1'b0;
    end else if (pl_q[1] && !pl_q[2]) begin
      poll_q <= 1'b1;
    end else if (pop) begin
      poll_q <= 1'b0;
    end
  end

  // Words leave on falling link edges, most significant bit first.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q   <= '0;
      bits_q <= 5'h0;
      o_sdo  <= 1'b0;
    end else if (pop) begin
      sh_q   <= buf_q[rp_q].data;
      bits_q <= imu_seq_pkg::WORD_BITS;
      o_sdo  <= buf_q[rp_q].data[imu_seq_pkg::WORD_W-1];
    end else if (lk_fall && bits_q != 5'h0) begin
      sh_q   <= {sh_q[imu_seq_pkg::WORD_W-2:0], 1'b0};
      bits_q <= bits_q - 5'h1;
      o_sdo  <= sh_q[imu_seq_pkg::WORD_W-2];
    end
  end

  // 4-wire owns its data pin; 3-wire drives only during a word.
  assign o_sdo_oe = !i_ctrl.spi_wire_select || (bits_q != 5'h0);

  // Line one frames words in stabilisation mode; line two rises at wake
  // and, in low latency, pulses per word.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_line_one <= 1'b0;
      o_irq_line_two <= 1'b0;
    end else begin
      o_irq_line_one <= (o_mode == imu_seq_pkg::MD_OIS) && (bits_q != 5'h0);
      if (o_mode == imu_seq_pkg::MD_OPTICAL_STAB_LOW_LATENCY && o_data_ready) begin
        o_irq_line_two <= pop;
      end else begin
        o_irq_line_two <= (st_q == imu_seq_pkg::ST_WAKE) ||
                          (st_q == imu_seq_pkg::ST_SETTLE) || o_data_ready;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence s_wake_req;
    st_q == imu_seq_pkg::ST_DEFAULT && want && !i_ctrl.sensor_shutdown;
  endsequence
  sequence s_settle_end;
    st_q == imu_seq_pkg::ST_SETTLE && want && !i_ctrl.sensor_shutdown &&
    tick && per_q == imu_seq_pkg::SETTLE_LAST;
  endsequence
  property p_boot_end;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_q == imu_seq_pkg::ST_BOOT && cnt_q == 32'h0) |=>
    st_q == imu_seq_pkg::ST_DEFAULT;
  endproperty
  a_boot_end: assert property (p_boot_end) else $error("boot end missed");
  property p_reboot;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_q == imu_seq_pkg::ST_PDOWN && !i_ctrl.sensor_shutdown) |=>
    (st_q == imu_seq_pkg::ST_BOOT && cnt_q == BOOT_CYC - 1);
  endproperty
  a_reboot: assert property (p_reboot) else $error("no full reboot");
  property p_wake_line;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_wake_req |=> st_q == imu_seq_pkg::ST_WAKE ##1 o_irq_line_two;
  endproperty
  a_wake_line: assert property (p_wake_line) else $error("wake line late");
  property p_gyro_wake;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_wake_req and i_ctrl.gyro_on) |=>
    cnt_q == ($past(warm_q) ? WARM_CYC : GYRO_CYC) - 1;
  endproperty
  a_gyro_wake: assert property (p_gyro_wake) else $error("gyro wake len");
  property p_acc_wake;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_wake_req and i_ctrl.accel_on && !i_ctrl.gyro_on && !i_ctrl.mag_on &&
     want_mode == imu_seq_pkg::MD_RAW) |=> cnt_q == ACC_CYC - 1;
  endproperty
  a_acc_wake: assert property (p_acc_wake) else $error("accel wake len");
  property p_settle;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_settle_end |=> o_data_ready;
  endproperty
  a_settle: assert property (p_settle) else $error("settle end missed");
  property p_run_from;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_data_ready) |-> $past(st_q) == imu_seq_pkg::ST_SETTLE;
  endproperty
  a_run_from: assert property (p_run_from) else $error("run too early");
  property p_idle_off;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q == imu_seq_pkg::ST_DEFAULT |-> !o_data_ready && !o_accel_avail;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("sensor on idle");
  property p_ois_acc;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_mode == imu_seq_pkg::MD_OIS |-> !o_accel_avail;
  endproperty
  a_ois_acc: assert property (p_ois_acc) else $error("accel in stab mode");
  property p_wires;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    pop |=> o_sdo_oe;
  endproperty
  a_wires: assert property (p_wires) else $error("data pin not driven");
  property p_poll;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (pop && od) |-> poll_q ##1 !poll_q || (pl_q[1] && !pl_q[2]);
  endproperty
  a_poll: assert property (p_poll) else $error("load without poll");
  property p_keep;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q == imu_seq_pkg::ST_PDOWN |=> $stable(o_mode) && $stable(o_out_kind);
  endproperty
  a_keep: assert property (p_keep) else $error("contents lost");
  property p_kind;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data_ready && o_mode == imu_seq_pkg::MD_FUSE9 |->
    o_out_kind == imu_seq_pkg::OUT_FUSE9;
  endproperty
  a_kind: assert property (p_kind) else $error("wrong output form");
  // In low latency every word load must show on line two one cycle later.
  property p_ll_line;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_mode == imu_seq_pkg::MD_OPTICAL_STAB_LOW_LATENCY && o_data_ready && pop) |=> o_irq_line_two;
  endproperty
  a_ll_line: assert property (p_ll_line) else $error("no line two pulse");
endmodule : imu_mode_power_sequencer

// *** logic/imu_seq_pkg.sv ***
// Package with constants and types of the mode and power sequencer.
package imu_seq_pkg;
  // ********************************************************
  // Clock and times
  // ********************************************************
  localparam int unsigned CLK_HZ   = 50_000_000; // Core clock rate.
  localparam real T_BOOT_S         = 1.75;       // Boot time, seconds.
  localparam real T_GYRO_MS        = 60.0;       // Gyro wake-up, ms.
  localparam real T_ACC_MS         = 3.0;        // Accel wake-up, ms.
  localparam real T_MAG_MS         = 12.0;       // Mag wake-up, ms.
  localparam real T_WARM_MS        = 5.0;        // Warm-start wake-up, ms.
  localparam int unsigned BOOT_CYC = int'($ceil(T_BOOT_S * CLK_HZ));
  localparam int unsigned GYRO_CYC = int'($ceil(T_GYRO_MS * CLK_HZ / 1000.0));
  localparam int unsigned ACC_CYC  = int'($ceil(T_ACC_MS * CLK_HZ / 1000.0));
  localparam int unsigned MAG_CYC  = int'($ceil(T_MAG_MS * CLK_HZ / 1000.0));
  localparam int unsigned WARM_CYC = int'($ceil(T_WARM_MS * CLK_HZ / 1000.0));
  localparam logic [1:0] SETTLE_LAST = 2'h2; // Third rate period ends settling.
  localparam logic [1:0] STOP_LAST   = 2'h1; // Second rate tick ends shutdown.
  // ********************************************************
  // Rate codes and widths
  // ********************************************************
  localparam logic [2:0] GRATE_OIS  = 3'h6; // Optical stabilisation.
  localparam logic [2:0] GRATE_LL   = 3'h7; // Low-latency stabilisation.
  localparam logic [2:0] GRATE_WARM = 3'h4; // Gyro warm start.
  localparam logic [2:0] ARATE_LL   = 3'h0; // Accel code for low latency.
  localparam int unsigned WORD_W    = 16;   // Stream word width.
  localparam int unsigned ODR_W     = 24;   // Rate period counter width.
  localparam logic [4:0] WORD_BITS  = 5'h10; // Bits per serial word.
  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [2:0] {ST_BOOT, ST_DEFAULT, ST_WAKE, ST_SETTLE,
                            ST_RUN, ST_STOP, ST_PDOWN} state_t;
  typedef enum logic [2:0] {MD_OFF, MD_RAW, MD_OIS, MD_OPTICAL_STAB_LOW_LATENCY,
                            MD_FUSE6, MD_FUSE9} mode_t;
  typedef enum logic [1:0] {OUT_RAW, OUT_FUSE6, OUT_FUSE9} out_kind_t;
  typedef struct packed {
    logic       sensor_shutdown;  // Power-down request.
    logic       spi_wire_select;  // 1 selects 3-wire, 0 selects 4-wire.
    logic       on_demand_select; // Host polls fusion results.
    logic       accel_on;         // Accelerometer enable.
    logic       gyro_on;          // Gyroscope enable.
    logic       mag_on;           // Magnetometer enable.
    logic       fusion_on;        // Fusion enable.
    logic [2:0] gyro_rate_code;   // Gyro rate code.
    logic [2:0] accel_rate_code;  // Accel rate code.
  } ctrl_t;
  typedef struct packed {
    logic [WORD_W-1:0] data; // One sample or fusion word.
  } sample_t;
endpackage : imu_seq_pkg

// *** test/imu_host_model.sv ***
// Host processor model: serial clock, poll pin and word capture.
`timescale 1ns/1ps
module imu_host_model (
  output logic      o_link_clk, // Serial clock, held low between frames.
  output logic      o_poll,     // Poll pin.
  input  wire logic i_sdo       // Serial data from the device.
);
  // ************************************************
  // Frame and poll tasks
  // ************************************************
  initial begin
    o_link_clk = 1'b0;
    o_poll     = 1'b0;
  end
  // Each bit is sampled just before the fall that shifts it out.
  // Pin moves sit 3 ns after a core edge so that they never race a sampling edge.
  task automatic read_word(output logic [15:0] w);
    #3;
    for (int i = 15; i >= 0; i--) begin
      o_link_clk = 1'b1;
      #80;
      w[i] = i_sdo;
      o_link_clk = 1'b0;
      #80;
    end
    #197;
  endtask : read_word
  // The pulse outlasts the three-stage synchroniser.
  task automatic poll_pulse();
    #3;
    o_poll = 1'b1;
    #100;
    o_poll = 1'b0;
    #97;
  endtask : poll_pulse
endmodule : imu_host_model

// *** test/imu_mode_power_sequencer_test.sv ***
// Self-checking bench of the mode and power sequencer.
`timescale 1ns/1ps
module imu_mode_power_sequencer_test;
  // ************************************************
  // Shortened counts and signals
  // ************************************************
  localparam int B = 50, G = 40, A = 10, M = 20, W = 15, O = 8; // Short counts.
  logic                   clk, rst_n, valid, ready, lclk, poll, sdo, oe;
  logic                   irq1, irq2, avail, drdy, busy;
  imu_seq_pkg::ctrl_t     ctrl;     // Control bits.
  imu_seq_pkg::sample_t   sample;   // Word to the buffer.
  imu_seq_pkg::mode_t     mode;     // Reported mode.
  imu_seq_pkg::out_kind_t kind;     // Reported output form.
  logic [15:0]            w;        // Word seen by the host.
  int                     fails, checks, n;
  imu_mode_power_sequencer #(.BOOT_CYC(B), .GYRO_CYC(G), .ACC_CYC(A), .MAG_CYC(M),
    .WARM_CYC(W)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ctrl(ctrl),
    .i_odr_cycles(24'(O)), .i_sample(sample), .i_sample_valid(valid), .o_sample_ready(ready),
    .i_link_clk(lclk), .i_poll(poll), .o_sdo(sdo), .o_sdo_oe(oe), .o_irq_line_one(irq1),
    .o_irq_line_two(irq2), .o_mode(mode), .o_out_kind(kind), .o_accel_avail(avail),
    .o_data_ready(drdy), .o_boot_busy(busy));
  imu_host_model u_host (.o_link_clk(lclk), .o_poll(poll), .i_sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Bounded wait for drdy (sel 0) or busy (sel 1) to reach a level.
  task automatic wait_lvl(input bit sel, input logic lvl, output int k);
    for (k = 1; k < 3000; k++) begin
      @(posedge clk);
      if ((sel ? busy : drdy) === lvl) break;
    end
    if (k == 3000) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_lvl
  function automatic imu_seq_pkg::ctrl_t mk(input logic a, g, m, f, input logic [2:0] gr);
    mk = '0;
    {mk.accel_on, mk.gyro_on, mk.mag_on, mk.fusion_on, mk.gyro_rate_code} = {a, g, m, f, gr};
  endfunction : mk
  // Start a mode, time it from the request, then check what is reported.
  task automatic go(input imu_seq_pkg::ctrl_t c, input int wk, input logic [15:0] md, kd,
                    input logic av);
    ctrl <= c;
    wait_lvl(1'b0, 1'b1, n);
    check(16'(n >= wk + 2 * O && n <= wk + 3 * O + 4), 16'h0001);
    check(16'(irq2), 16'h0001);
    check(16'(mode), md);
    check(16'(kind), kd);
    check(16'(avail), 16'(av));
    check(16'(oe), 16'(!c.spi_wire_select));
  endtask : go
  // Turn the sensors off; the stop ends inside two rate periods.
  task automatic stop(input logic [2:0] gr);
    ctrl <= mk(0, 0, 0, 0, gr);
    wait_lvl(1'b0, 1'b0, n);
    check(16'(n <= 2 * O + 3), 16'h0001);
    repeat (3 * O) @(posedge clk);
    check(16'(irq2), 16'h0000);
  endtask : stop
  task automatic push(input logic [15:0] d);
    sample <= d;
    valid  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (ready === 1'b1) break;
    end
    valid  <= 1'b0;
    if (n == 100) begin
      fails++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask : push
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    imu_seq_pkg::ctrl_t c;
    {fails, checks} = '0;
    {rst_n, valid, ctrl, sample} = '0;
    repeat (2) @(posedge clk);
    check(16'(busy), 16'h0001);
    rst_n <= 1'b1;
    wait_lvl(1'b1, 1'b0, n);
    check(16'(n >= B - 1 && n <= B + 3), 16'h0001);
    check(16'(drdy), 16'h0000);
    go(mk(0, 1, 0, 0, 0), G, imu_seq_pkg::MD_RAW, imu_seq_pkg::OUT_RAW, 1);
    stop(0);
    go(mk(1, 0, 0, 0, 0), A, imu_seq_pkg::MD_RAW, imu_seq_pkg::OUT_RAW, 1);
    stop(0);
    go(mk(1, 0, 1, 0, 0), M, imu_seq_pkg::MD_RAW, imu_seq_pkg::OUT_RAW, 1);
    stop(0);
    go(mk(0, 0, 0, 0, 7), G, imu_seq_pkg::MD_OPTICAL_STAB_LOW_LATENCY, imu_seq_pkg::OUT_RAW, 1);
    push(16'h5AA5);
    u_host.read_word(w);
    check(w, 16'h5AA5);
    stop(0);
    go(mk(1, 1, 0, 1, 0), G, imu_seq_pkg::MD_FUSE6, imu_seq_pkg::OUT_FUSE6, 1);
    stop(0);
    go(mk(1, 1, 1, 1, 0), G, imu_seq_pkg::MD_FUSE9, imu_seq_pkg::OUT_FUSE9, 1);
    stop(0);
    // Fill the buffer until it refuses, then drain it over the link.
    c = mk(0, 0, 0, 0, 6);
    c.spi_wire_select = 1'b1;
    go(c, G, imu_seq_pkg::MD_OIS, imu_seq_pkg::OUT_RAW, 0);
    push(16'hA5C3);
    push(16'h0F81);
    push(16'hFFFE);
    check(16'(ready), 16'h0000);
    check({14'h0, irq1, oe}, 16'h0003);
    for (int i = 2; i >= 0; i--) begin
      u_host.read_word(w);
      check(w, i == 2 ? 16'hA5C3 : i == 1 ? 16'h0F81 : 16'hFFFE);
    end
    @(posedge clk);
    check({14'h0, irq1, oe}, 16'h0000);
    stop(0);
    // On-demand fusion words leave only after a poll.
    c = mk(1, 1, 0, 1, 0);
    {c.on_demand_select, c.spi_wire_select} = 2'h3;
    go(c, G, imu_seq_pkg::MD_FUSE6, imu_seq_pkg::OUT_FUSE6, 1);
    push(16'h3C5A);
    repeat (8) @(posedge clk);
    check(16'(oe), 16'h0000);
    u_host.poll_pulse();
    repeat (4) @(posedge clk);
    check(16'(oe), 16'h0001);
    u_host.read_word(w);
    check(w, 16'h3C5A);
    @(posedge clk);
    stop(4);
    go(mk(0, 1, 0, 0, 4), W, imu_seq_pkg::MD_RAW, imu_seq_pkg::OUT_RAW, 1);
    stop(0);
    // Power-down keeps the sensors off; leaving it reboots in full.
    c = '0;
    c.sensor_shutdown = 1'b1;
    ctrl <= c;
    repeat (4) @(posedge clk);
    check({14'h0, busy, drdy}, 16'h0000);
    check(16'(mode), imu_seq_pkg::MD_RAW);
    ctrl <= '0;
    wait_lvl(1'b1, 1'b1, n);
    wait_lvl(1'b1, 1'b0, n);
    check(16'(n >= B - 1 && n <= B + 3), 16'h0001);
    tally_and_finish();
  end
endmodule : imu_mode_power_sequencer_test
